// ### hw/ddcsp_pkg.sv
// Shared constants, types and lookups of the deflection RAM serial slave port
package ddcsp_pkg;
	// Slave identity and telegram layout
	localparam logic [6:0] SLAVE_ADDR = 7'h46;
	localparam logic READ_BIT = 1'b1;
	// Sub-address map
	localparam int RAM_WORDS = 96;
	localparam logic [6:0] RAM_LIMIT = 7'(RAM_WORDS);
	localparam logic [6:0] LAST_LOC = 7'h7e;
	localparam logic [6:0] ALIGN_FIRST = 7'h0a;
	localparam logic [6:0] ALIGN_LAST = 7'h29;
	localparam logic [6:0] CTRL_A_ADDR = 7'h2a;
	localparam logic [6:0] CTRL_B_ADDR = 7'h2b;
	// Filter select field inside control word A
	localparam int FILTER_LSB = 0;
	// Values after reset
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [1:0] FILTER_RESET = 2'h0;
	// Service interval and post-reset wait
	localparam int SERVICE_NS = 32000;
	localparam int LINK_PERIOD_NS = 15;
	localparam int SYS_PERIOD_NS = 100;
	localparam int POR_WAIT_CYC = (SERVICE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// Master bit timing: one quarter of an SCL period, 100 kHz at 10 MHz
	localparam int SCL_QUARTER_CYC = 25;
	// Byte positions within a telegram
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_SUB = 2'h1;
	localparam logic [1:0] BYTE_HI = 2'h2;
	localparam logic [1:0] BYTE_LO = 2'h3;

	typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_MACK} ddcsp_dev_state_t;
	typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} ddcsp_mst_state_t;

	// Fixed raster data above the RAM window; the pattern is arbitrary
	function automatic logic [15:0] rom_word(input logic [6:0] a);
		rom_word = {8'ha5, 1'b0, a};
	endfunction : rom_word
endpackage : ddcsp_pkg

// ### hw/ddcsp_link_if.sv
// Two-wire link between bus master and slave port, open-drain resolution
`timescale 1ns/1ns
`default_nettype none
interface ddcsp_link_if;
	logic m_scl_oe;
	logic m_scl_o;
	logic m_sda_oe;
	logic m_sda_o;
	logic d_sda_oe;
	logic d_sda_o;
	logic scl;
	logic sda;

	// Pull-ups win unless someone drives low
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

	modport master (output m_scl_oe, output m_scl_o, output m_sda_oe, output m_sda_o,
		input scl, input sda);
	modport device (output d_sda_oe, output d_sda_o, input scl, input sda);
endinterface : ddcsp_link_if
`default_nettype wire

// ### hw/ddcsp_device.sv
// Slave end: two-wire port into the deflection RAM, clocked by the link clock
`timescale 1ns/1ns
`default_nettype none
module ddcsp_device #(
	parameter int LINK_PERIOD_NS = ddcsp_pkg::LINK_PERIOD_NS
) (
	// Link clock and resets
	input wire logic link_clk,
	input wire logic rst,
	input wire logic reset_n,
	input wire logic main_supply,
	// Two-wire link
	ddcsp_link_if.device link,
	// Controller side
	input wire logic [5:0] status_bits,
	output logic [15:0] ctrl_word_a,
	output logic [15:0] ctrl_word_b,
	output logic [1:0] filter_sel,
	output logic port_ready
);
	localparam int SERVICE_CYC = (ddcsp_pkg::SERVICE_NS / LINK_PERIOD_NS < 1) ? 1 :
		ddcsp_pkg::SERVICE_NS / LINK_PERIOD_NS;

	logic rst_s1, rst_s2, rstn_s1, rstn_s2, sup_s1, sup_s2, dev_rst;
	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [15:0] svc_cnt;
	logic tick;
	ddcsp_pkg::ddcsp_dev_state_t state;
	logic [2:0] bit_cnt;
	logic [1:0] byte_no, nb;
	logic [7:0] sh, next_sh, tx_next, status_byte;
	logic rw, ack_ph;
	logic [6:0] ptr;
	logic [7:0] hi_byte;
	logic [15:0] rd_word;
	logic rx_done, wr_done;
	logic pend;
	logic [6:0] pend_addr;
	logic [15:0] pend_data;
	logic sda_oe, sda_out;
	logic [15:0] ram [ddcsp_pkg::RAM_WORDS];
	// Byte to shift out for a given position in the read telegram
	function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic [15:0] w,
		input logic [7:0] st);
		if (idx == ddcsp_pkg::BYTE_HI) begin
			tx_byte = w[15:8];
		end else if (idx == ddcsp_pkg::BYTE_LO) begin
			tx_byte = w[7:0];
		end else begin
			tx_byte = st;
		end
	endfunction : tx_byte
	// Reset sources all arrive from other domains, so two flops each
	always_ff @(posedge link_clk) begin
		rst_s1 <= rst;
		rst_s2 <= rst_s1;
		rstn_s1 <= reset_n;
		rstn_s2 <= rstn_s1;
		sup_s1 <= main_supply;
		sup_s2 <= sup_s1;
	end
	// Combined reset; missing supply also holds the port quiet
	always_ff @(posedge link_clk) begin
		dev_rst <= rst_s2 | ~rstn_s2 | ~sup_s2;
	end
	// Bus pins synchronised; edge logic compares the second stage with the third
	always_ff @(posedge link_clk) begin
		scl_s1 <= link.scl;
		scl_s2 <= scl_s1;
		scl_d <= scl_s2;
		sda_s1 <= link.sda;
		sda_s2 <= sda_s1;
		sda_d <= sda_s2;
	end
	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_cond = scl_s2 & scl_d & ~sda_s2 & sda_d;
	assign stop_cond = scl_s2 & scl_d & sda_s2 & ~sda_d;
	// Processor service interval
	always_ff @(posedge link_clk) begin
		if (dev_rst) begin
			svc_cnt <= 16'h0000;
		end else if (tick) begin
			svc_cnt <= 16'h0000;
		end else begin
			svc_cnt <= svc_cnt + 16'h0001;
		end
	end
	assign tick = (svc_cnt == 16'(SERVICE_CYC - 1));
	// Port comes alive at the first service slot after reset
	always_ff @(posedge link_clk) begin
		if (dev_rst) begin
			port_ready <= 1'b0;
		end else if (tick) begin
			port_ready <= 1'b1;
		end
	end
	assign next_sh = {sh[6:0], sda_s2};
	assign nb = byte_no + 2'h1;
	assign status_byte = {pend, port_ready, status_bits};
	assign tx_next = tx_byte(nb, rd_word, status_byte);
	assign rx_done = (state == ddcsp_pkg::DS_RX) && scl_rise && (bit_cnt == 3'h7);
	assign wr_done = rx_done && (byte_no == ddcsp_pkg::BYTE_LO) && !rw;
	// Bit-level protocol engine; never drives SCL, so it cannot be a master
	always_ff @(posedge link_clk) begin
		if (dev_rst) begin
			state <= ddcsp_pkg::DS_IDLE;
			bit_cnt <= 3'h0;
			byte_no <= 2'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			ack_ph <= 1'b0;
			ptr <= 7'h00;
			hi_byte <= 8'h00;
			rd_word <= 16'h0000;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state <= ddcsp_pkg::DS_RX;
			bit_cnt <= 3'h0;
			byte_no <= ddcsp_pkg::BYTE_ADDR;
			sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state <= ddcsp_pkg::DS_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
				ddcsp_pkg::DS_RX: begin
					if (scl_rise) begin
						sh <= next_sh;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state <= ddcsp_pkg::DS_ACK;
							ack_ph <= 1'b0;
							if (byte_no == ddcsp_pkg::BYTE_ADDR) begin
								// Foreign address or not yet ready: stay silent
								if (next_sh[7:1] != ddcsp_pkg::SLAVE_ADDR || !port_ready) begin
									state <= ddcsp_pkg::DS_IDLE;
								end
								rw <= (next_sh[0] == ddcsp_pkg::READ_BIT);
								// Word for a read is fetched at address time
								if (ptr < ddcsp_pkg::RAM_LIMIT) begin
									rd_word <= ram[ptr];
								end else if (ptr <= ddcsp_pkg::LAST_LOC) begin
									rd_word <= ddcsp_pkg::rom_word(ptr);
								end else begin
									rd_word <= 16'h0000;
								end
							end else if (byte_no == ddcsp_pkg::BYTE_SUB) begin
								ptr <= next_sh[6:0];
							end else if (byte_no == ddcsp_pkg::BYTE_HI) begin
								hi_byte <= next_sh;
							end
						end
					end
				end
				ddcsp_pkg::DS_ACK: begin
					if (scl_fall) begin
						if (!ack_ph) begin
							sda_oe <= 1'b1;
							ack_ph <= 1'b1;
						end else begin
							ack_ph <= 1'b0;
							byte_no <= nb;
							bit_cnt <= 3'h0;
							if (rw) begin
								sh <= tx_next;
								sda_oe <= ~tx_next[7];
								state <= ddcsp_pkg::DS_TX;
							end else begin
								sda_oe <= 1'b0;
								// A fifth byte of a write is not taken
								state <= (byte_no == ddcsp_pkg::BYTE_LO) ?
									ddcsp_pkg::DS_IDLE : ddcsp_pkg::DS_RX;
							end
						end
					end
				end
				ddcsp_pkg::DS_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							sda_oe <= 1'b0;
							state <= ddcsp_pkg::DS_MACK;
						end else begin
							sh <= {sh[6:0], 1'b0};
							sda_oe <= ~sh[6];
							bit_cnt <= bit_cnt + 3'h1;
						end
					end
				end
				ddcsp_pkg::DS_MACK: begin
					if (scl_rise) begin
						if (sda_s2) begin
							state <= ddcsp_pkg::DS_IDLE;
						end else begin
							state <= ddcsp_pkg::DS_ACK;
							ack_ph <= 1'b1;
						end
					end
				end
				default: begin
					sda_oe <= 1'b0;
				end
			endcase
		end
	end
	// Only a full word becomes pending; a stop earlier drops it
	always_ff @(posedge link_clk) begin
		if (dev_rst) begin
			pend <= 1'b0;
			pend_addr <= 7'h00;
			pend_data <= 16'h0000;
		end else if (wr_done) begin
			pend <= 1'b1;
			pend_addr <= ptr;
			pend_data <= {hi_byte, next_sh};
		end else if (tick) begin
			pend <= 1'b0;
		end
	end
	// Commit at the service slot; ROM area is read only
	always_ff @(posedge link_clk) begin
		if (tick && pend && pend_addr < ddcsp_pkg::RAM_LIMIT) begin
			ram[pend_addr] <= pend_data;
		end
	end

	// Control words and the filter select pins
	always_ff @(posedge link_clk) begin
		if (dev_rst) begin
			ctrl_word_a <= ddcsp_pkg::CTRL_RESET;
			ctrl_word_b <= ddcsp_pkg::CTRL_RESET;
			filter_sel <= ddcsp_pkg::FILTER_RESET;
		end else if (tick && pend) begin
			if (pend_addr == ddcsp_pkg::CTRL_A_ADDR) begin
				ctrl_word_a <= pend_data;
				filter_sel <= pend_data[ddcsp_pkg::FILTER_LSB +: 2];
			end else if (pend_addr == ddcsp_pkg::CTRL_B_ADDR) begin
				ctrl_word_b <= pend_data;
			end
		end
	end

	// Open drain: the driven level is always low
	always_ff @(posedge link_clk) begin
		sda_out <= 1'b0;
	end

	assign link.d_sda_oe = sda_oe;
	assign link.d_sda_o = sda_out;
endmodule : ddcsp_device
`default_nettype wire

// ### hw/ddcsp_master.sv
// Master end: issues write and read telegrams, makes SCL from sys_clk
`timescale 1ns/1ns
`default_nettype none
module ddcsp_master #(
	parameter int QUARTER_CYC = ddcsp_pkg::SCL_QUARTER_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Two-wire link
	ddcsp_link_if.master link,
	// User request
	input wire logic req,
	input wire logic rd,
	input wire logic [6:0] sub_addr,
	input wire logic [15:0] wdata,
	// User answer
	output logic busy,
	output logic done,
	output logic nack,
	output logic [7:0] rdata_status,
	output logic [15:0] rdata_word
);
	ddcsp_pkg::ddcsp_mst_state_t state;
	logic sda_s1, sda_s2;
	logic [15:0] qcnt;
	logic qtick;
	logic [1:0] q, byte_i;
	logic [3:0] bit_i;
	logic [7:0] sh;
	logic rd_q, tx_phase;
	logic [6:0] sub_q;
	logic [15:0] wd_q;
	logic [15:0] por_cnt;
	logic por_done;
	logic scl_oe, sda_oe, drv_lo;

	// Returning SDA comes from the device's domain
	always_ff @(posedge sys_clk) begin
		sda_s1 <= link.sda;
		sda_s2 <= sda_s1;
	end

	// Wait out the slave's start-up before the first telegram
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			por_cnt <= 16'h0000;
			por_done <= 1'b0;
		end else if (por_cnt == 16'(ddcsp_pkg::POR_WAIT_CYC - 1)) begin
			por_done <= 1'b1;
		end else begin
			por_cnt <= por_cnt + 16'h0001;
		end
	end

	// Quarter-bit divider, runs only during a telegram
	always_ff @(posedge sys_clk) begin
		if (rst || state == ddcsp_pkg::MS_IDLE || qtick) begin
			qcnt <= 16'h0000;
		end else begin
			qcnt <= qcnt + 16'h0001;
		end
	end

	assign qtick = (qcnt == 16'(QUARTER_CYC - 1));
	assign tx_phase = (byte_i == ddcsp_pkg::BYTE_ADDR) || !rd_q;

	// Telegram sequencer: start, four bytes with ack slots, stop
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ddcsp_pkg::MS_IDLE;
			q <= 2'h0;
			byte_i <= 2'h0;
			bit_i <= 4'h0;
			sh <= 8'h00;
			rd_q <= 1'b0;
			sub_q <= 7'h00;
			wd_q <= 16'h0000;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b1;
			done <= 1'b0;
			nack <= 1'b0;
			rdata_status <= 8'h00;
			rdata_word <= 16'h0000;
		end else begin
			done <= 1'b0;
			case (state)
				ddcsp_pkg::MS_IDLE: begin
					busy <= ~por_done;
					if (req && por_done) begin
						busy <= 1'b1;
						nack <= 1'b0;
						rd_q <= rd;
						sub_q <= sub_addr;
						wd_q <= wdata;
						sh <= {ddcsp_pkg::SLAVE_ADDR, rd};
						byte_i <= ddcsp_pkg::BYTE_ADDR;
						q <= 2'h0;
						state <= ddcsp_pkg::MS_START;
					end
				end
				ddcsp_pkg::MS_START: begin
					if (qtick) begin
						q <= q + 2'h1;
						if (q == 2'h0) begin
							sda_oe <= 1'b1;
						end else if (q == 2'h2) begin
							scl_oe <= 1'b1;
							bit_i <= 4'h0;
							q <= 2'h0;
							state <= ddcsp_pkg::MS_BIT;
						end
					end
				end
				ddcsp_pkg::MS_BIT: begin
					if (qtick) begin
						q <= q + 2'h1;
						if (q == 2'h0) begin
							if (bit_i == 4'h8) begin
								sda_oe <= !tx_phase && (byte_i != ddcsp_pkg::BYTE_LO);
							end else begin
								sda_oe <= tx_phase && !sh[7];
							end
						end else if (q == 2'h1) begin
							scl_oe <= 1'b0;
						end else if (q == 2'h2) begin
							if (bit_i == 4'h8) begin
								nack <= tx_phase && sda_s2;
							end else begin
								sh <= {sh[6:0], sda_s2};
							end
						end else begin
							scl_oe <= 1'b1;
							bit_i <= bit_i + 4'h1;
							if (bit_i == 4'h8) begin
								bit_i <= 4'h0;
								if (!tx_phase) begin
									if (byte_i == ddcsp_pkg::BYTE_SUB) begin
										rdata_status <= sh;
									end else if (byte_i == ddcsp_pkg::BYTE_HI) begin
										rdata_word[15:8] <= sh;
									end else begin
										rdata_word[7:0] <= sh;
									end
								end
								byte_i <= byte_i + 2'h1;
								if (nack || byte_i == ddcsp_pkg::BYTE_LO) begin
									state <= ddcsp_pkg::MS_STOP;
								end
								if (byte_i == ddcsp_pkg::BYTE_ADDR) begin
									sh <= {1'b0, sub_q};
								end else if (byte_i == ddcsp_pkg::BYTE_SUB) begin
									sh <= wd_q[15:8];
								end else begin
									sh <= wd_q[7:0];
								end
							end
						end
					end
				end
				default: begin
					if (qtick) begin
						q <= q + 2'h1;
						if (q == 2'h0) begin
							sda_oe <= 1'b1;
						end else if (q == 2'h1) begin
							scl_oe <= 1'b0;
						end else if (q == 2'h2) begin
							sda_oe <= 1'b0;
						end else begin
							done <= 1'b1;
							state <= ddcsp_pkg::MS_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Open drain: driven level is always low
	always_ff @(posedge sys_clk) begin
		drv_lo <= 1'b0;
	end

	assign link.m_scl_oe = scl_oe;
	assign link.m_scl_o = drv_lo;
	assign link.m_sda_oe = sda_oe;
	assign link.m_sda_o = drv_lo;
endmodule : ddcsp_master
`default_nettype wire

// ### verification/ddcsp_link_props.sv
// Checker of the two-wire link between master end and slave port
`timescale 1ns/1ns
`default_nettype none
module ddcsp_link_props #(
	parameter int QUARTER_CYC = ddcsp_pkg::SCL_QUARTER_CYC
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic link_clk,
	input wire logic rst,
	// Link signals
	input wire logic m_scl_oe,
	input wire logic m_scl_o,
	input wire logic m_sda_oe,
	input wire logic m_sda_o,
	input wire logic d_sda_oe,
	input wire logic d_sda_o,
	input wire logic scl,
	input wire logic sda
);
	// First SCL low after a start comes within two quarters plus margin
	localparam int START_MAX = 4 * QUARTER_CYC;

	// Start and stop framing as seen from the master
	sequence start_s;
		$rose(m_sda_oe) && scl;
	endsequence
	sequence stop_s;
		$fell(m_sda_oe) && scl;
	endsequence

	// Open-drain: every driver may only pull low
	master_low_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		!m_scl_o && !m_sda_o) else $error("master drives a line high");
	device_low_only_a: assert property (@(posedge link_clk) disable iff (rst)
		!d_sda_o) else $error("device drives SDA high");
	// Slave data and ack only move while SCL is low
	device_edge_low_a: assert property (@(posedge link_clk) disable iff (rst)
		$changed(d_sda_oe) |-> !scl) else $error("device moved SDA with SCL high");
	// With SCL high, SDA moves only as start or stop by the master
	bit_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
		scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
		else $error("SDA changed while SCL high");
	start_then_clock_a: assert property (@(posedge sys_clk) disable iff (rst)
		start_s |-> scl ##[1:START_MAX] !scl) else $error("no clock after start");
	stop_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
		stop_s |-> ##1 (scl && sda)[*2]) else $error("bus not idle after stop");
	// Master clock high and low phases last at least three system clocks
	scl_high_len_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(scl) |-> scl[*3]) else $error("SCL high phase too short");
	scl_low_len_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(scl) |-> (!scl)[*3]) else $error("SCL low phase too short");
	// Scenario coverage
	start_seen_c: cover property (@(posedge sys_clk) disable iff (rst) start_s);
endmodule : ddcsp_link_props
`default_nettype wire

// ### verification/tb_top.sv
// Testbench joining the master end and the slave port across the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int QC = 2;
	localparam logic [5:0] STAT = 6'h2d;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic reset_n = 1'b1;
	logic main_supply = 1'b1;
	logic req = 1'b0;
	logic rd = 1'b0;
	logic [6:0] sub_addr = 7'h00;
	logic [15:0] wdata = 16'h0000;
	logic busy, done, nack, port_ready;
	logic [7:0] rdata_status;
	logic [15:0] rdata_word, ctrl_word_a, ctrl_word_b;
	logic [1:0] filter_sel;
	int bad_count = 0;
	int checks_done = 0;

	ddcsp_link_if link ();
	// Short quarter and long link period keep the run brief
	ddcsp_master #(.QUARTER_CYC(QC)) i_ddcsp_master (.sys_clk(sys_clk), .rst(rst),
		.link(link), .req(req), .rd(rd), .sub_addr(sub_addr), .wdata(wdata),
		.busy(busy), .done(done), .nack(nack), .rdata_status(rdata_status),
		.rdata_word(rdata_word));
	ddcsp_device #(.LINK_PERIOD_NS(1000)) i_ddcsp_device (.link_clk(link_clk), .rst(rst),
		.reset_n(reset_n), .main_supply(main_supply), .link(link), .status_bits(STAT),
		.ctrl_word_a(ctrl_word_a), .ctrl_word_b(ctrl_word_b), .filter_sel(filter_sel),
		.port_ready(port_ready));
	ddcsp_link_props #(.QUARTER_CYC(QC)) i_ddcsp_link_props (.sys_clk(sys_clk),
		.link_clk(link_clk), .rst(rst), .m_scl_oe(link.m_scl_oe), .m_scl_o(link.m_scl_o),
		.m_sda_oe(link.m_sda_oe), .m_sda_o(link.m_sda_o), .d_sda_oe(link.d_sda_oe),
		.d_sda_o(link.d_sda_o), .scl(link.scl), .sda(link.sda));

	// System clock 100 ns
	initial forever #50 sys_clk = ~sys_clk;
	// Link clock 15 ns, offset by 3 ns; its rising edge still meets a system clock rising edge every 300 ns
	initial begin
		#3;
		forever begin
			#7 link_clk = ~link_clk;
			#8 link_clk = ~link_clk;
		end
	end

	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// One telegram from request to done, then time for a service tick
	task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		req <= 1'b1;
		rd <= r;
		sub_addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		req <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		cmp("done", 16'h0001, 16'(done));
		repeat (8) @(posedge sys_clk);
	endtask : xfer

	// Write a word, then read it back with the status byte in front
	task automatic wrrd(input logic [6:0] a, input logic [15:0] d, input logic [15:0] e);
		xfer(1'b0, a, d);
		cmp("write nack", 16'h0000, 16'(nack));
		xfer(1'b1, a, 16'h0000);
		cmp("read nack", 16'h0000, 16'(nack));
		cmp("status", {10'h001, STAT}, 16'(rdata_status));
		cmp("word", e, rdata_word);
	endtask : wrrd

	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		cmp("busy", 16'h0001, 16'(busy));
		cmp("ctrl a", 16'h0000, ctrl_word_a);
		cmp("filter", 16'h0000, 16'(filter_sel));
		// Ends of the alignment window, ROM above RAM, address past the last location
		wrrd(7'h0a, 16'h12fc, 16'h12fc);
		wrrd(7'h29, 16'hc301, 16'hc301);
		wrrd(7'h70, 16'h5555, 16'ha570);
		wrrd(7'h7f, 16'h5555, 16'h0000);
		// Control words and the filter pins
		wrrd(7'h2a, 16'h8cb7, 16'h8cb7);
		cmp("ctrl a", 16'h8cb7, ctrl_word_a);
		cmp("filter", 16'h0003, 16'(filter_sel));
		wrrd(7'h2b, 16'h4e21, 16'h4e21);
		cmp("ctrl b", 16'h4e21, ctrl_word_b);
		// External reset low clears the port
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cmp("ready", 16'h0000, 16'(port_ready));
		cmp("ctrl a", 16'h0000, ctrl_word_a);
		cmp("ctrl b", 16'h0000, ctrl_word_b);
		cmp("filter", 16'h0000, 16'(filter_sel));
		reset_n <= 1'b1;
		// Supply absent: address is not answered
		main_supply <= 1'b0;
		repeat (4) @(posedge sys_clk);
		xfer(1'b0, 7'h2a, 16'h0001);
		cmp("nack", 16'h0001, 16'(nack));
		cmp("ctrl a", 16'h0000, ctrl_word_a);
		main_supply <= 1'b1;
		repeat (10) @(posedge sys_clk);
		cmp("ready", 16'h0001, 16'(port_ready));
		wrrd(7'h10, 16'ha00f, 16'ha00f);
		test_done();
	end

	// Watchdog: the tests need well under a third of this span
	initial begin
		repeat (30000) @(posedge sys_clk);
		bad_count++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
